// >>> verilog/tcc_top.sv
`timescale 1ns/1ps
// Function
// - timing mode holds output prepare level
// - mode 001 sets prepare on match
// - mode 010 clears prepare on match
// - mode 011 toggles prepare on match
// - modes 100/101 force prepare low/high
// - PWM mode 0 level from direction, compare
// - PWM mode 1 is inverse level
// - PWM changes only on entry from timing mode, result change or fast trigger
// - outputs derived from prepare with polarities
// - protection 11 locks output mode and shadow bits while mode select is output
// - shadow value moves to active at update
// - fast enable: in PWM modes trigger edge sets level from direction
// - mode select picks output or input source
// - mode select writable only while disabled
// - low half-word or word access accepted
// - compare event sets channel event flag in output mode
module tcc_top #(
	parameter int CW = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [tcc_pkg::AW-1:0] busAddr,
	input wire logic [tcc_pkg::DW-1:0] busWdata,
	input wire logic [3:0] busBe,
	input wire logic busWr,
	input wire logic busRd,
	output logic [tcc_pkg::DW-1:0] busRdata,
	input wire logic [CW-1:0] counterValue,
	input wire logic countDown,
	input wire logic updateEvent,
	input wire logic trigEdge,
	input wire logic ownFilteredInput,
	input wire logic neighbourFilteredInput,
	input wire logic internalTriggerInput,
	output logic outputPrepareSignal,
	output logic channelOutput,
	output logic complementaryOutput,
	output logic channelEventFlag,
	output logic channelInputSource
);
	import tcc_pkg::*;

	// ************************************************************
	// decode helpers
	// ************************************************************
	function automatic logic isPwm(input logic [2:0] mode);
		return (mode == CM_PWM0) || (mode == CM_PWM1);
	endfunction

	function automatic logic hit(input logic [AW-1:0] addr, input logic [AW-1:0] off);
		return addr == off;
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	logic [1:0] channelModeSelect;
	logic compareFastEnable;
	logic compareShadowEnable;
	logic [2:0] compareOutMode;
	logic channelEnableBit;
	logic channelPolarity;
	logic complementaryPolarity;
	logic [1:0] protectionLevel;
	logic [CW-1:0] shadowCv;
	logic [CW-1:0] activeCv;
	logic [2:0] prevOutMode;
	logic pwmResQ;
	logic [DW-1:0] rdMux;
	logic wrLanes;
	logic modeWr;
	logic chenWr;
	logic cvWr;
	logic protWr;
	logic flagWr;
	logic writeLock;
	logic pwmRes;
	logic pwmLvl;
	logic fastLvl;
	logic fastHit;
	logic enterPwm;
	logic resChange;
	logic flagSet;
	logic flagClr;
	logic next_prepare;
	logic [CW-1:0] next_shadowCv;

	tcc_cmp_if #(.CW(CW)) cmpBus ();

	tcc_cmp uCmp (
		.clk(clk),
		.nrst(nrst),
		.port(cmpBus.cmp)
	);

	assign cmpBus.cnt = counterValue;
	assign cmpBus.cv = activeCv;

	// ************************************************************
	// register write decode
	// ************************************************************
	// byte-only writes are dropped; low half-word lanes must both be on
	assign wrLanes = busWr && (busBe[1:0] == LANE_LO);
	assign modeWr = wrLanes && hit(busAddr, OFF_MODE);
	assign chenWr = wrLanes && hit(busAddr, OFF_CHEN);
	assign cvWr = wrLanes && hit(busAddr, OFF_CV);
	assign protWr = wrLanes && hit(busAddr, OFF_PROTECTION_LEVEL);
	assign flagWr = wrLanes && hit(busAddr, OFF_FLAG);
	assign writeLock = (protectionLevel == PROTECTION_LEVEL_LOCK) && (channelModeSelect == MS_OUT);

	// ************************************************************
	// channel mode control register
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			channelModeSelect <= RST_MODE[MS_LSB +: 2];
			compareFastEnable <= RST_MODE[FEN_BIT];
			compareShadowEnable <= RST_MODE[SEN_BIT];
			compareOutMode <= RST_MODE[COM_LSB +: 3];
		end else if (modeWr) begin
			if (!channelEnableBit) begin
				channelModeSelect <= busWdata[MS_LSB +: 2];
			end
			compareFastEnable <= busWdata[FEN_BIT];
			if (!writeLock) begin
				compareShadowEnable <= busWdata[SEN_BIT];
				compareOutMode <= busWdata[COM_LSB +: 3];
			end
		end
	end

	// ************************************************************
	// enable, polarity and protection registers
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			channelEnableBit <= 1'b0;
			channelPolarity <= 1'b0;
			complementaryPolarity <= 1'b0;
		end else if (chenWr) begin
			channelEnableBit <= busWdata[EN_BIT];
			channelPolarity <= busWdata[POL_BIT];
			complementaryPolarity <= busWdata[NPOL_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			protectionLevel <= 2'h0;
		end else if (protWr) begin
			protectionLevel <= busWdata[PROTECTION_LEVEL_LSB +: 2];
		end
	end

	// ************************************************************
	// compare value and its shadow
	// ************************************************************
	assign next_shadowCv = cvWr ? busWdata[CW-1:0] : shadowCv;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			shadowCv <= '0;
		end else begin
			shadowCv <= next_shadowCv;
		end
	end

	// a write landing with the update is carried along, not lost
	always_ff @(posedge clk) begin
		if (!nrst) begin
			activeCv <= '0;
		end else if (compareShadowEnable) begin
			if (updateEvent) begin
				activeCv <= next_shadowCv;
			end
		end else if (cvWr) begin
			activeCv <= busWdata[CW-1:0];
		end
	end

	// ************************************************************
	// output prepare generation
	// ************************************************************
	assign pwmRes = countDown ? ~cmpBus.gt : cmpBus.lt;
	assign pwmLvl = (compareOutMode == CM_PWM0) ? pwmRes : ~pwmRes;
	assign fastLvl = (compareOutMode == CM_PWM0) ? countDown : ~countDown;
	assign fastHit = compareFastEnable && trigEdge && isPwm(compareOutMode);
	assign enterPwm = isPwm(compareOutMode) && (prevOutMode == CM_TIMING);
	assign resChange = pwmRes != pwmResQ;

	always_comb begin
		next_prepare = outputPrepareSignal;
		case (compareOutMode)
			CM_TIMING: begin
				next_prepare = outputPrepareSignal;
			end
			CM_SET: begin
				if (cmpBus.matchEv) begin
					next_prepare = 1'b1;
				end
			end
			CM_CLR: begin
				if (cmpBus.matchEv) begin
					next_prepare = 1'b0;
				end
			end
			CM_TOG: begin
				if (cmpBus.matchEv) begin
					next_prepare = ~outputPrepareSignal;
				end
			end
			CM_FLOW: begin
				next_prepare = 1'b0;
			end
			CM_FHIGH: begin
				next_prepare = 1'b1;
			end
			CM_PWM0, CM_PWM1: begin
				// fast trigger wins over a comparison change in the same cycle
				if (fastHit) begin
					next_prepare = fastLvl;
				end else if (enterPwm || resChange) begin
					next_prepare = pwmLvl;
				end
			end
			default: begin
				next_prepare = outputPrepareSignal;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			outputPrepareSignal <= 1'b0;
			prevOutMode <= CM_TIMING;
			pwmResQ <= 1'b0;
		end else begin
			outputPrepareSignal <= next_prepare;
			prevOutMode <= compareOutMode;
			pwmResQ <= pwmRes;
		end
	end

	// ************************************************************
	// channel outputs and input source
	// ************************************************************
	// outputs idle low while disabled or in input mode
	always_ff @(posedge clk) begin
		if (!nrst) begin
			channelOutput <= 1'b0;
			complementaryOutput <= 1'b0;
		end else if (channelEnableBit && (channelModeSelect == MS_OUT)) begin
			channelOutput <= next_prepare ^ channelPolarity;
			complementaryOutput <= ~next_prepare ^ complementaryPolarity;
		end else begin
			channelOutput <= 1'b0;
			complementaryOutput <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			channelInputSource <= 1'b0;
		end else begin
			case (channelModeSelect)
				MS_OWN: channelInputSource <= ownFilteredInput;
				MS_NEIGH: channelInputSource <= neighbourFilteredInput;
				MS_TRIG: channelInputSource <= internalTriggerInput;
				default: channelInputSource <= 1'b0;
			endcase
		end
	end

	// ************************************************************
	// channel event flag
	// ************************************************************
	assign flagSet = (channelModeSelect == MS_OUT) && cmpBus.matchEv;
	assign flagClr = flagWr && !busWdata[FLAG_BIT];

	always_ff @(posedge clk) begin
		if (!nrst) begin
			channelEventFlag <= 1'b0;
		end else if (flagSet) begin
			channelEventFlag <= 1'b1;
		end else if (flagClr) begin
			channelEventFlag <= 1'b0;
		end
	end

	// ************************************************************
	// read back
	// ************************************************************
	always_comb begin
		rdMux = '0;
		case (busAddr)
			OFF_FLAG: rdMux[FLAG_BIT] = channelEventFlag;
			OFF_MODE: begin
				rdMux[MS_LSB +: 2] = channelModeSelect;
				rdMux[FEN_BIT] = compareFastEnable;
				rdMux[SEN_BIT] = compareShadowEnable;
				rdMux[COM_LSB +: 3] = compareOutMode;
			end
			OFF_CHEN: begin
				rdMux[EN_BIT] = channelEnableBit;
				rdMux[POL_BIT] = channelPolarity;
				rdMux[NPOL_BIT] = complementaryPolarity;
			end
			OFF_CV: rdMux[CW-1:0] = shadowCv;
			OFF_PROTECTION_LEVEL: rdMux[PROTECTION_LEVEL_LSB +: 2] = protectionLevel;
			OFF_STAT: begin
				rdMux[0] = outputPrepareSignal;
				rdMux[1] = channelOutput;
				rdMux[2] = complementaryOutput;
				rdMux[3] = cmpBus.eq;
				rdMux[CVA_LSB +: CW] = activeCv;
			end
			default: rdMux = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			busRdata <= '0;
		end else if (busRd) begin
			busRdata <= rdMux;
		end else begin
			busRdata <= '0;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	timing_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		(compareOutMode == CM_TIMING) |=> $stable(outputPrepareSignal))
		else $error("prepare moved in timing mode");

	set_match_a: assert property (@(posedge clk) disable iff (!nrst)
		(compareOutMode == CM_SET) && cmpBus.matchEv |=> outputPrepareSignal)
		else $error("prepare not set on match");

	clr_match_a: assert property (@(posedge clk) disable iff (!nrst)
		(compareOutMode == CM_CLR) && cmpBus.matchEv |=> !outputPrepareSignal)
		else $error("prepare not cleared on match");

	toggle_match_a: assert property (@(posedge clk) disable iff (!nrst)
		(compareOutMode == CM_TOG) && cmpBus.matchEv
		|=> outputPrepareSignal != $past(outputPrepareSignal))
		else $error("prepare did not toggle on match");

	force_level_a: assert property (@(posedge clk) disable iff (!nrst)
		(compareOutMode == CM_FHIGH) |=> outputPrepareSignal)
		else $error("prepare not forced high");

	force_low_a: assert property (@(posedge clk) disable iff (!nrst)
		(compareOutMode == CM_FLOW) [*2] |-> !outputPrepareSignal)
		else $error("prepare not forced low");

	pwm0_up_a: assert property (@(posedge clk) disable iff (!nrst)
		(compareOutMode == CM_PWM0) && !countDown && resChange && !fastHit
		|=> outputPrepareSignal == $past(cmpBus.lt))
		else $error("pwm mode 0 up level wrong");

	pwm1_down_a: assert property (@(posedge clk) disable iff (!nrst)
		(compareOutMode == CM_PWM1) && countDown && resChange && !fastHit
		|=> outputPrepareSignal == $past(cmpBus.gt))
		else $error("pwm mode 1 down level wrong");

	pwm_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		isPwm(compareOutMode) && !enterPwm && !resChange && !fastHit
		|=> $stable(outputPrepareSignal))
		else $error("pwm level changed without cause");

	out_polarity_a: assert property (@(posedge clk) disable iff (!nrst)
		channelEnableBit && (channelModeSelect == MS_OUT)
		|=> (channelOutput == (outputPrepareSignal ^ $past(channelPolarity)))
		&& (complementaryOutput != channelOutput) == ($past(channelPolarity)
		== $past(complementaryPolarity)))
		else $error("channel outputs disagree with prepare");

	protection_level_lock_a: assert property (@(posedge clk) disable iff (!nrst)
		writeLock && modeWr |=> $stable(compareOutMode) && $stable(compareShadowEnable))
		else $error("locked field was written");

	shadow_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		compareShadowEnable && !updateEvent |=> $stable(activeCv))
		else $error("active value moved without update");

	direct_cv_a: assert property (@(posedge clk) disable iff (!nrst)
		cvWr && !compareShadowEnable |=> activeCv == $past(busWdata[CW-1:0]))
		else $error("direct compare write not applied");

	fast_hit_a: assert property (@(posedge clk) disable iff (!nrst)
		fastHit |=> outputPrepareSignal == $past(fastLvl))
		else $error("fast trigger not applied");

	mode_lock_a: assert property (@(posedge clk) disable iff (!nrst)
		channelEnableBit |=> $stable(channelModeSelect))
		else $error("mode select changed while enabled");

	flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
		flagSet |=> channelEventFlag)
		else $error("compare event did not set flag");
endmodule

// >>> verilog/tcc_pkg.sv
package tcc_pkg;
	// ************************************************************
	// bus geometry
	// ************************************************************
	localparam int AW = 8;
	localparam int DW = 32;
	localparam logic [1:0] LANE_LO = 2'h3;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [AW-1:0] OFF_FLAG = 8'h10;
	localparam logic [AW-1:0] OFF_MODE = 8'h18;
	localparam logic [AW-1:0] OFF_CHEN = 8'h20;
	localparam logic [AW-1:0] OFF_CV = 8'h34;
	localparam logic [AW-1:0] OFF_PROTECTION_LEVEL = 8'h44;
	localparam logic [AW-1:0] OFF_STAT = 8'h48;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int MS_LSB = 0;
	localparam int FEN_BIT = 2;
	localparam int SEN_BIT = 3;
	localparam int COM_LSB = 4;
	localparam int EN_BIT = 0;
	localparam int POL_BIT = 1;
	localparam int NPOL_BIT = 3;
	localparam int FLAG_BIT = 1;
	localparam int PROTECTION_LEVEL_LSB = 0;
	localparam int CVA_LSB = 16;

	// ************************************************************
	// encodings and reset values
	// ************************************************************
	localparam logic [2:0] CM_TIMING = 3'h0;
	localparam logic [2:0] CM_SET = 3'h1;
	localparam logic [2:0] CM_CLR = 3'h2;
	localparam logic [2:0] CM_TOG = 3'h3;
	localparam logic [2:0] CM_FLOW = 3'h4;
	localparam logic [2:0] CM_FHIGH = 3'h5;
	localparam logic [2:0] CM_PWM0 = 3'h6;
	localparam logic [2:0] CM_PWM1 = 3'h7;
	localparam logic [1:0] MS_OUT = 2'h0;
	localparam logic [1:0] MS_OWN = 2'h1;
	localparam logic [1:0] MS_NEIGH = 2'h2;
	localparam logic [1:0] MS_TRIG = 2'h3;
	localparam logic [1:0] PROTECTION_LEVEL_LOCK = 2'h3;
	localparam logic [15:0] RST_MODE = 16'h0000;
endpackage

// >>> verilog/tcc_cmp_if.sv
`timescale 1ns/1ps
interface tcc_cmp_if #(parameter int CW = 16);
	logic [CW-1:0] cnt;
	logic [CW-1:0] cv;
	logic eq;
	logic lt;
	logic gt;
	logic matchEv;
	modport src (output cnt, output cv, input eq, input lt, input gt, input matchEv);
	modport cmp (input cnt, input cv, output eq, output lt, output gt, output matchEv);
endinterface

// >>> verilog/tcc_cmp.sv
`timescale 1ns/1ps
module tcc_cmp (
	input wire logic clk,
	input wire logic nrst,
	tcc_cmp_if.cmp port
);
	logic eqQ;

	assign port.eq = (port.cnt == port.cv);
	assign port.lt = (port.cnt < port.cv);
	assign port.gt = (port.cnt > port.cv);

	// a stalled counter sitting on the compare value gives one event only
	always_ff @(posedge clk) begin
		if (!nrst) begin
			// counter and compare value both reset to zero: no event out of reset
			eqQ <= 1'b1;
		end else begin
			eqQ <= port.eq;
		end
	end

	assign port.matchEv = port.eq & ~eqQ;

	match_edge_a: assert property (@(posedge clk) disable iff (!nrst)
		port.matchEv |=> !port.matchEv)
		else $error("compare event lasted more than one cycle");
endmodule

// >>> testbench/tcc_partner.sv
`timescale 1ns/1ps
// ************************************************************
// counter, trigger and input-source model
// ************************************************************
module tcc_partner #(
	parameter int CW = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic loadEn,
	input wire logic [CW-1:0] loadVal,
	input wire logic dirDown,
	input wire logic updReq,
	input wire logic trigReq,
	input wire logic [2:0] srcLevels,
	output logic [CW-1:0] counterValue,
	output logic countDown,
	output logic updateEvent,
	output logic trigEdge,
	output logic ownFilteredInput,
	output logic neighbourFilteredInput,
	output logic internalTriggerInput
);
	// counter moves only on command, so every match lands on a known cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			counterValue <= '0;
			countDown <= 1'b0;
			updateEvent <= 1'b0;
			trigEdge <= 1'b0;
		end else begin
			if (loadEn) begin
				counterValue <= loadVal;
			end
			countDown <= dirDown;
			updateEvent <= updReq;
			trigEdge <= trigReq;
		end
	end

	always_ff @(posedge clk) begin
		ownFilteredInput <= srcLevels[0];
		neighbourFilteredInput <= srcLevels[1];
		internalTriggerInput <= srcLevels[2];
	end
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import tcc_pkg::*;
	logic clk, nrst, busWr, busRd, loadEn, dirDown, updReq, trigReq;
	logic [AW-1:0] busAddr;
	logic [DW-1:0] busWdata, busRdata, d;
	logic [3:0] busBe;
	logic [15:0] loadVal, counterValue;
	logic [2:0] srcLevels;
	logic countDown, updateEvent, trigEdge, ownIn, neighIn, trigIn;
	logic outputPrepareSignal, channelOutput, complementaryOutput;
	logic channelEventFlag, channelInputSource;
	int errors, compares;

	tcc_top #(.CW(16)) tcc_top_i (.clk(clk), .nrst(nrst), .busAddr(busAddr),
		.busWdata(busWdata), .busBe(busBe), .busWr(busWr), .busRd(busRd),
		.busRdata(busRdata), .counterValue(counterValue), .countDown(countDown),
		.updateEvent(updateEvent), .trigEdge(trigEdge), .ownFilteredInput(ownIn),
		.neighbourFilteredInput(neighIn), .internalTriggerInput(trigIn),
		.outputPrepareSignal(outputPrepareSignal), .channelOutput(channelOutput),
		.complementaryOutput(complementaryOutput), .channelEventFlag(channelEventFlag),
		.channelInputSource(channelInputSource));

	tcc_partner #(.CW(16)) tcc_partner_i (.clk(clk), .nrst(nrst), .loadEn(loadEn),
		.loadVal(loadVal), .dirDown(dirDown), .updReq(updReq), .trigReq(trigReq),
		.srcLevels(srcLevels), .counterValue(counterValue), .countDown(countDown),
		.updateEvent(updateEvent), .trigEdge(trigEdge), .ownFilteredInput(ownIn),
		.neighbourFilteredInput(neighIn), .internalTriggerInput(trigIn));

	always #5 clk = ~clk;

	// ************************************************************
	// checks and report
	// ************************************************************
	task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t: word got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkBit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t: bit got %b expected %b", $time, got, exp);
		end
	endtask

	task automatic results;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ************************************************************
	// bus and stimulus tasks
	// ************************************************************
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wrBe(input logic [7:0] a, input logic [31:0] v, input logic [3:0] be);
		@(posedge clk);
		busAddr <= a;
		busWdata <= v;
		busBe <= be;
		busWr <= 1'b1;
		@(posedge clk);
		busWr <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		wrBe(a, v, 4'hf);
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		busAddr <= a;
		busRd <= 1'b1;
		@(posedge clk);
		busRd <= 1'b0;
		#1;
		v = busRdata;
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd(a, v);
		chkWord(v, exp);
	endtask

	task automatic setMode(input logic [1:0] ms, input logic fen, input logic sen,
		input logic [2:0] com);
		wr(OFF_MODE, {25'h0, com, sen, fen, ms});
		idle(2);
	endtask

	task automatic setCnt(input logic [15:0] v, input logic dn = 1'b0);
		@(posedge clk);
		loadEn <= 1'b1;
		loadVal <= v;
		dirDown <= dn;
		@(posedge clk);
		loadEn <= 1'b0;
		idle(3);
	endtask

	task automatic pulse(input logic trig);
		@(posedge clk);
		if (trig) begin
			trigReq <= 1'b1;
		end else begin
			updReq <= 1'b1;
		end
		@(posedge clk);
		trigReq <= 1'b0;
		updReq <= 1'b0;
		idle(3);
	endtask

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		clk = 0;
		nrst = 0;
		{busWr, busRd, loadEn, dirDown, updReq, trigReq} = '0;
		busAddr = '0;
		busWdata = '0;
		busBe = '0;
		loadVal = '0;
		srcLevels = '0;
		errors = 0;
		compares = 0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		idle(1);
		rdChk(OFF_MODE, 32'h0);
		rdChk(OFF_FLAG, 32'h0);
		rdChk(8'h04, 32'h0);
		wrBe(OFF_MODE, 32'h11, 4'hc);
		rdChk(OFF_MODE, 32'h0);
		wrBe(OFF_MODE, 32'h11, 4'h3);
		rdChk(OFF_MODE, 32'h11);
		$display("test registers done");

		setMode(MS_OUT, 0, 0, CM_TIMING);
		wr(OFF_CHEN, 32'h1);
		wr(OFF_CV, 32'h40);
		rd(OFF_STAT, d);
		chkWord(d >> 16, 32'h40);
		wr(OFF_FLAG, 32'h0);
		setMode(MS_OUT, 0, 0, CM_SET);
		setCnt(16'h40);
		chkBit(outputPrepareSignal, 1);
		chkBit(channelEventFlag, 1);
		chkBit(channelOutput, 1);
		chkBit(complementaryOutput, 0);
		setMode(MS_OUT, 0, 0, CM_CLR);
		setCnt(16'h10);
		setCnt(16'h40);
		chkBit(outputPrepareSignal, 0);
		setMode(MS_OUT, 0, 0, CM_TOG);
		for (int i = 0; i < 2; i++) begin
			setCnt(16'h10);
			setCnt(16'h40);
			chkBit(outputPrepareSignal, i == 0);
		end
		setMode(MS_OUT, 0, 0, CM_FLOW);
		chkBit(outputPrepareSignal, 0);
		setMode(MS_OUT, 0, 0, CM_FHIGH);
		chkBit(outputPrepareSignal, 1);
		setMode(MS_OUT, 1, 0, CM_TIMING);
		setCnt(16'h10);
		setCnt(16'h40);
		chkBit(outputPrepareSignal, 1);
		pulse(1);
		chkBit(outputPrepareSignal, 1);
		wr(OFF_CHEN, 32'hb);
		idle(2);
		chkBit(channelOutput, 0);
		chkBit(complementaryOutput, 1);
		wr(OFF_CHEN, 32'h1);
		rdChk(OFF_FLAG, 32'h2);
		wr(OFF_FLAG, 32'h0);
		rdChk(OFF_FLAG, 32'h0);
		$display("test compare modes done");

		// shadow on, as software should for pulse-width modes
		setMode(MS_OUT, 0, 1, CM_PWM0);
		chkBit(outputPrepareSignal, 0);
		setCnt(16'h10);
		chkBit(outputPrepareSignal, 1);
		setCnt(16'h50);
		chkBit(outputPrepareSignal, 0);
		setCnt(16'h30, 1);
		chkBit(outputPrepareSignal, 1);
		setCnt(16'h40, 1);
		chkBit(outputPrepareSignal, 1);
		setMode(MS_OUT, 0, 1, CM_PWM1);
		setCnt(16'h50, 1);
		chkBit(outputPrepareSignal, 1);
		setCnt(16'h30, 1);
		chkBit(outputPrepareSignal, 0);
		setCnt(16'h50);
		chkBit(outputPrepareSignal, 1);
		setCnt(16'h10);
		chkBit(outputPrepareSignal, 0);
		setMode(MS_OUT, 0, 1, CM_TIMING);
		setMode(MS_OUT, 1, 1, CM_PWM0);
		chkBit(outputPrepareSignal, 1);
		pulse(1);
		chkBit(outputPrepareSignal, 0);
		chkBit(channelOutput, 0);
		wr(OFF_CV, 32'h20);
		rd(OFF_STAT, d);
		chkWord(d >> 16, 32'h40);
		rdChk(OFF_CV, 32'h20);
		pulse(0);
		rd(OFF_STAT, d);
		chkWord(d >> 16, 32'h20);
		setMode(MS_OUT, 1, 1, CM_PWM1);
		chkBit(outputPrepareSignal, 0);
		pulse(1);
		chkBit(outputPrepareSignal, 1);
		chkBit(channelOutput, 1);
		$display("test pwm and shadow done");

		wr(OFF_MODE, 32'h6d);
		rdChk(OFF_MODE, 32'h6c);
		wr(OFF_PROTECTION_LEVEL, 32'h3);
		wr(OFF_MODE, 32'h40);
		rdChk(OFF_MODE, 32'h68);
		wr(OFF_CHEN, 32'h0);
		// trigger selection sits outside this block; assumed done before mode 3
		for (int m = 1; m < 4; m++) begin
			wr(OFF_MODE, 32'(m));
			@(posedge clk);
			srcLevels <= 3'(1 << (m - 1));
			idle(3);
			chkBit(channelInputSource, 1);
			@(posedge clk);
			srcLevels <= ~3'(1 << (m - 1));
			idle(3);
			chkBit(channelInputSource, 0);
		end
		$display("test locks and inputs done");
		results();
	end

	// whole run is well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		$display("BAD %0t: watchdog expired", $time);
		results();
	end
endmodule
